// [logic/pcrp_defines.svh]
`ifndef PCRP_DEFINES_SVH
`define PCRP_DEFINES_SVH
// ==========================================
// Timing
`define PCRP_CLK_PERIOD_NS 25
`define PCRP_RESET_MIN_US 5
`define PCRP_RESET_MIN_CYCLES ((`PCRP_RESET_MIN_US * 1000 + `PCRP_CLK_PERIOD_NS - 1) / `PCRP_CLK_PERIOD_NS)
`define PCRP_SYNC_RDY_CYCLES 2
// ==========================================
// Register defaults
`define PCRP_REG_RESET 8'h00
`define PCRP_ALARM_ADDR 8'h03
`define PCRP_ALARM_SET_ADDR 8'hFF
`endif

// [logic/pcrp_device.sv]
`timescale 1ns/1ps
`include "pcrp_defines.svh"
// Summary of operation
// - Pmode low async, high sync
// - Eight-bit address selects the register
// - Drive data only during selected read
// - Strobes ignored without chip select
// - Read starts on read strobe fall
// - Write starts on write strobe fall
// - Ready low when access completes
// - Interrupt on alarm bit rise, read clears
// - Host: address, chip select, then read
// - Host waits ready, captures, raises read
// - Write data before strobe; store then ready
// - Host raises chip select between commands
// - Sync mode timed by host clock
// - Sync ready within two clocks plus margin
// - Reset clears interface and registers
// - Reset held minimum; registers take defaults (bench holds reset only 6 clocks, 150 ns)
module pcrp_device
  import pcrp_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  pcrp_if.device bus,
  input wire logic [7:0] alarm_in,
  output logic [7:0] ctrl_out
);
  // ==========================================
  // Strobe qualification
  pcrp_state_type state_q;
  pcrp_state_type state_d;
  logic [7:0] regs_q [DEPTH];
  logic [7:0] alarm_q;
  logic [7:0] alarm_prev_q;
  logic pclk_q;
  logic rd_prev_q;
  logic wr_prev_q;
  logic [1:0] cnt_q;
  logic [7:0] dout_q;
  logic oe_q;
  logic rdy_n_q;
  logic int_n_q;
  logic [7:0] ctrl_q;
  wire rd_act = !bus.cs_n && !bus.rd_n;
  wire wr_act = !bus.cs_n && !bus.wr_n;
  wire rd_fall = rd_act && rd_prev_q;
  wire wr_fall = wr_act && wr_prev_q;
  wire pclk_rise = bus.pclk && !pclk_q;
  // Async mode counts two system clocks in wait; sync waits two host clock edges
  wire tick = bus.pmode ? pclk_rise : 1'b1;
  wire cnt_done = (cnt_q == 2'(`PCRP_SYNC_RDY_CYCLES - 1));
  wire is_alarm = (bus.addr == `PCRP_ALARM_ADDR);
  wire alarm_read = (state_q == PCRP_WAIT) && rd_act && cnt_done && tick && is_alarm;
  wire [7:0] alarm_new = alarm_in & ~alarm_prev_q;
  wire released = !rd_act && !wr_act;
  always_comb begin
    state_d = state_q;
    case (state_q)
      PCRP_IDLE: begin
        if (rd_fall || wr_fall) begin
          state_d = PCRP_WAIT;
        end
      end
      PCRP_WAIT: begin
        if (released) begin
          state_d = PCRP_IDLE;
        end else if (cnt_done && tick) begin
          state_d = PCRP_DONE;
        end
      end
      PCRP_DONE: begin
        if (released) begin
          state_d = PCRP_IDLE;
        end
      end
      default: begin
        state_d = PCRP_IDLE;
      end
    endcase
  end

  // ==========================================
  // Next-value selection
  wire [1:0] cnt_step = (tick && !cnt_done) ? cnt_q + 2'h1 : cnt_q;
  wire [1:0] cnt_d = (state_q == PCRP_WAIT) ? cnt_step : 2'h0;
  wire rdy_n_d = (state_d != PCRP_DONE);
  wire oe_d = rd_act && ((state_d != PCRP_IDLE) || rd_fall);
  wire [7:0] rd_sel = is_alarm ? alarm_q : regs_q[bus.addr];
  // Follow the bus while the read stands, so a late address still shows
  wire [7:0] dout_d = rd_act ? rd_sel : dout_q;
  // A write with no data driven still answers, but stores nothing
  wire wr_commit = (state_q == PCRP_WAIT) && wr_act && cnt_done && tick && bus.d_host_oe;
  wire [7:0] alarm_kept = alarm_read ? 8'h00 : alarm_q;
  // New alarm wins over a clearing read in the same cycle
  wire [7:0] alarm_d = alarm_kept | alarm_new;
  wire int_n_d = (alarm_d == 8'h00);

  // ==========================================
  // Sequencing
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= PCRP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Idle levels on reset, so no false strobe edge follows it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pclk_q <= 1'b0;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else begin
      pclk_q <= bus.pclk;
      rd_prev_q <= !rd_act;
      wr_prev_q <= !wr_act;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdy_n_q <= 1'b1;
    end else begin
      rdy_n_q <= rdy_n_d;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dout_q <= 8'h00;
    end else begin
      dout_q <= dout_d;
    end
  end

  // ==========================================
  // Register storage
  genvar gi;
  for (gi = 0; gi < DEPTH; gi++) begin : g_reg
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        regs_q[gi] <= `PCRP_REG_RESET;
      end else if (wr_commit && (bus.addr == 8'(gi))) begin
        regs_q[gi] <= bus.d_host;
      end
    end
  end

  // ==========================================
  // Alarm and interrupt
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      alarm_prev_q <= 8'h00;
    end else begin
      alarm_prev_q <= alarm_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      alarm_q <= 8'h00;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= int_n_d;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= 8'h00;
    end else begin
      ctrl_q <= regs_q[0];
    end
  end

  // ==========================================
  // Outputs
  assign bus.d_dev = dout_q;
  assign bus.d_dev_oe = oe_q;
  assign bus.rdy_n = rdy_n_q;
  assign bus.int_n = int_n_q;
  assign ctrl_out = ctrl_q;
endmodule : pcrp_device

// [logic/pcrp_host.sv]
`timescale 1ns/1ps
`include "pcrp_defines.svh"
module pcrp_host
  import pcrp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  pcrp_if.host bus,
  input wire logic sync_mode_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic irq_out
);
  // ==========================================
  // Cycle sequencer
  pcrp_hstate_type state_q;
  logic cs_n_q;
  logic rd_n_q;
  logic wr_n_q;
  logic oe_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic write_q;
  logic pclk_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic mode_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= PCRP_H_IDLE;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      oe_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      write_q <= 1'b0;
      pclk_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      // Host clock for sync mode, half the system rate
      pclk_q <= !pclk_q;
      irq_q <= !bus.int_n;
      mode_q <= sync_mode_in;
      done_q <= 1'b0;
      case (state_q)
        PCRP_H_IDLE: begin
          if (req_in) begin
            addr_q <= addr_in;
            wdata_q <= wdata_in;
            write_q <= write_in;
            oe_q <= write_in;
            state_q <= PCRP_H_SEL;
          end
        end
        PCRP_H_SEL: begin
          cs_n_q <= 1'b0;
          state_q <= PCRP_H_STB;
        end
        PCRP_H_STB: begin
          rd_n_q <= write_q;
          wr_n_q <= !write_q;
          if (!bus.rdy_n && (!rd_n_q || !wr_n_q)) begin
            if (!write_q) begin
              rdata_q <= bus.d_dev;
            end
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            state_q <= PCRP_H_END;
          end
        end
        PCRP_H_END: begin
          cs_n_q <= 1'b1;
          oe_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= PCRP_H_IDLE;
        end
        default: begin
          state_q <= PCRP_H_IDLE;
        end
      endcase
    end
  end
  assign bus.pmode = mode_q;
  assign bus.pclk = pclk_q;
  assign bus.addr = addr_q;
  assign bus.cs_n = cs_n_q;
  assign bus.rd_n = rd_n_q;
  assign bus.wr_n = wr_n_q;
  assign bus.d_host = wdata_q;
  assign bus.d_host_oe = oe_q;
  assign busy_out = (state_q != PCRP_H_IDLE);
  assign done_out = done_q;
  assign rdata_out = rdata_q;
  assign irq_out = irq_q;
endmodule : pcrp_host

// [logic/pcrp_if.sv]
`timescale 1ns/1ps
interface pcrp_if;
  logic pmode;
  logic [7:0] addr;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [7:0] d_host;
  logic d_host_oe;
  logic [7:0] d_dev;
  logic d_dev_oe;
  logic rdy_n;
  logic int_n;
  logic pclk;
  modport device (input pmode, addr, cs_n, rd_n, wr_n, d_host, d_host_oe, pclk,
    output d_dev, d_dev_oe, rdy_n, int_n);
  modport host (output pmode, addr, cs_n, rd_n, wr_n, d_host, d_host_oe, pclk,
    input d_dev, d_dev_oe, rdy_n, int_n);
endinterface : pcrp_if

// [logic/pcrp_pkg.sv]
package pcrp_pkg;
  typedef enum logic [1:0] {
    PCRP_IDLE = 2'b00,
    PCRP_WAIT = 2'b01,
    PCRP_DONE = 2'b10
  } pcrp_state_type;
  typedef enum logic [1:0] {
    PCRP_H_IDLE = 2'b00,
    PCRP_H_SEL = 2'b01,
    PCRP_H_STB = 2'b10,
    PCRP_H_END = 2'b11
  } pcrp_hstate_type;
endpackage : pcrp_pkg

// [verification/pcrp_properties.sv]
`timescale 1ns/1ps
// ====
// Port checker
module pcrp_properties (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic pmode,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic d_host_oe,
  input wire logic d_dev_oe,
  input wire logic rdy_n,
  input wire logic int_n
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ====
  // Device side
  property p_oe; d_dev_oe |-> !$past(cs_n) && !$past(rd_n); endproperty
  a_oe: assert property (p_oe) else $error("bus driven off read");
  property p_idle; cs_n |=> rdy_n [*2]; endproperty
  a_idle: assert property (p_idle) else $error("ready without select");
  property p_rd; !pmode && !cs_n && $fell(rd_n) |-> ##[1:4] !rdy_n; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_wr; !pmode && !cs_n && $fell(wr_n) |-> ##[1:4] !rdy_n; endproperty
  a_wr: assert property (p_wr) else $error("write not answered");
  // Two host clocks plus margin fits five cycles
  property p_syn; pmode && !cs_n && ($fell(rd_n) || $fell(wr_n)) |-> ##[1:5] !rdy_n; endproperty
  a_syn: assert property (p_syn) else $error("sync answer late");
  property p_rel; $rose(rd_n) || $rose(wr_n) |=> rdy_n && !d_dev_oe; endproperty
  a_rel: assert property (p_rel) else $error("ready held");
  // ====
  // Host side
  property p_hwr; $fell(wr_n) |-> d_host_oe; endproperty
  a_hwr: assert property (p_hwr) else $error("write data late");
  property p_ord; $fell(rd_n) || $fell(wr_n) |-> !cs_n && !$past(cs_n); endproperty
  a_ord: assert property (p_ord) else $error("strobe before select");
  property p_hold; $rose(rd_n) || $rose(wr_n) |-> !$past(rdy_n); endproperty
  a_hold: assert property (p_hold) else $error("strobe raised before ready");
  property p_csh; $rose(rd_n) || $rose(wr_n) |-> ##[1:2] cs_n; endproperty
  a_csh: assert property (p_csh) else $error("select held after cycle");
  c_rd: cover property (!rdy_n && !rd_n);
  c_wr: cover property (!rdy_n && !wr_n);
  c_int: cover property ($fell(int_n));
  c_syn: cover property (pmode && !rdy_n);
endmodule : pcrp_properties

// [verification/tb_top.sv]
`timescale 1ns/1ps
// ====
// Bench top
module tb_top;
  import pcrp_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic sync_mode_in = 1'b0;
  logic req_in = 1'b0;
  logic write_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] alarm_in = 8'h00;
  logic busy_out, done_out, irq_out;
  logic [7:0] rdata_out, ctrl_out, a, d;
  logic [8:0] e;
  logic [8:0] exp_q[$];
  logic [7:0] mem[256];
  int n_fail = 0, num_checks = 0, cyc = 0, seed = 67993;
  pcrp_if pcrp_if_i ();
  pcrp_device pcrp_device_i (.clk_in(clk_in), .rstn_in(rstn_in), .bus(pcrp_if_i.device),
    .alarm_in(alarm_in), .ctrl_out(ctrl_out));
  pcrp_host pcrp_host_i (.clk_in(clk_in), .rstn_in(rstn_in), .bus(pcrp_if_i.host),
    .sync_mode_in(sync_mode_in), .req_in(req_in), .write_in(write_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out),
    .irq_out(irq_out));
  pcrp_properties pcrp_properties_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .pmode(pcrp_if_i.pmode), .cs_n(pcrp_if_i.cs_n), .rd_n(pcrp_if_i.rd_n),
    .wr_n(pcrp_if_i.wr_n), .d_host_oe(pcrp_if_i.d_host_oe), .d_dev_oe(pcrp_if_i.d_dev_oe),
    .rdy_n(pcrp_if_i.rdy_n), .int_n(pcrp_if_i.int_n));
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // Expectation noted at launch, so later model edits cannot leak in
  task automatic op(input logic w, input logic [7:0] ad, input logic [7:0] dd);
    @(posedge clk_in iff busy_out !== 1'b1);
    exp_q.push_back({!w, mem[ad]});
    if (w) mem[ad] = dd;
    req_in <= 1'b1;
    write_in <= w;
    addr_in <= ad;
    wdata_in <= dd;
    @(posedge clk_in iff busy_out === 1'b1);
    req_in <= 1'b0;
    @(posedge clk_in iff done_out === 1'b1);
  endtask : op
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      print_verdict();
    end else if (done_out === 1'b1) begin
      e = exp_q.pop_front();
      if (e[8]) chk(rdata_out, e[7:0]);
    end
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      sync_mode_in <= m[0];
      op(1'b1, 8'h00, 8'ha5 ^ m[7:0]);
      repeat (2) @(posedge clk_in);
      chk(ctrl_out, 8'ha5 ^ m[7:0]);
      for (int i = 0; i < 6; i++) begin
        a = 8'($random(seed));
        d = 8'($random(seed));
        if (a == 8'h03) a = 8'h04;
        op(1'b1, a, d);
        op(1'b0, a, 8'h00);
      end
    end
    alarm_in <= 8'h05;
    repeat (8) @(posedge clk_in);
    chk({7'h00, irq_out}, 8'h01);
    mem[8'h03] = 8'h05;
    op(1'b0, 8'h03, 8'h00);
    mem[8'h03] = 8'h00;
    op(1'b0, 8'h03, 8'h00);
    repeat (4) @(posedge clk_in);
    chk({7'h00, irq_out}, 8'h00);
    chk(ctrl_out, mem[0]);
    rstn_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    @(posedge clk_in);
    chk(ctrl_out, 8'h00);
    op(1'b0, a, 8'h00);
    print_verdict();
  end
endmodule : tb_top
